/* verilog/dcf_pkg.sv */
// constants for the driver configuration and fault register slice
package dcf_pkg;

	// ----------------------------------------------------------------
	// register offsets (byte addresses on the internal register port)
	// ----------------------------------------------------------------
	localparam logic [7:0] DCF_OFS_GD_SETTINGS_TWO = 8'hAE;
	localparam logic [7:0] DCF_OFS_GD_FAULT_FLAGS = 8'hE0;
	localparam logic [7:0] DCF_OFS_CTRL_FAULT_FLAGS = 8'hE2;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] DCF_RST_GD_SETTINGS_TWO = 32'h01200000;
	localparam logic [31:0] DCF_RST_GD_FAULT_FLAGS = 32'h00000000;
	localparam logic [31:0] DCF_RST_CTRL_FAULT_FLAGS = 32'h00000000;

	// ----------------------------------------------------------------
	// configuration word field positions
	// ----------------------------------------------------------------
	localparam int DCF_CFG_PARITY_BIT = 31;
	localparam int DCF_CFG_DLY_COMP_BIT = 30;
	localparam int DCF_CFG_TDLY_MSB = 29;
	localparam int DCF_CFG_TDLY_LSB = 26;
	localparam int DCF_CFG_SLEW_BIT = 25;
	localparam int DCF_CFG_SEQ_OFF_BIT = 24;
	localparam int DCF_CFG_CUR_LIM_BIT = 23;
	localparam int DCF_CFG_VSEL_MSB = 22;
	localparam int DCF_CFG_VSEL_LSB = 21;
	localparam int DCF_CFG_OFF_BIT = 20;
	// writable bits; 19..0 are reserved and keep their reset value
	localparam logic [31:0] DCF_CFG_WR_MASK = 32'hFFF00000;

	// target delay: code 0 is automatic, else 0.4 us + (code-1) * 0.2 us
	localparam logic [3:0] DCF_TDLY_AUTO = 4'h0;
	localparam int DCF_TDLY_BASE_NS = 400;
	localparam int DCF_TDLY_STEP_NS = 200;

	// buck voltage codes
	localparam logic [1:0] DCF_VSEL_3V3 = 2'h0;
	localparam logic [1:0] DCF_VSEL_5V0 = 2'h1;
	localparam logic [1:0] DCF_VSEL_4V0 = 2'h2;
	localparam logic [1:0] DCF_VSEL_5V7 = 2'h3;

	// ----------------------------------------------------------------
	// gate-driver fault word field positions
	// ----------------------------------------------------------------
	localparam int DCF_FLT_SUMMARY_BIT = 31;
	localparam int DCF_FLT_SUPPLY_RST_BIT = 27;
	// individual fault bits: 30, 28, 26, 25, 23..16, 14..11
	localparam logic [31:0] DCF_FLT_IND_MASK = 32'h56FF7800;

	// synchroniser depth for pin-side inputs
	localparam int DCF_SYNC_STAGES = 2;

endpackage

/* verilog/dcf_sync.sv */
// two-flop level synchroniser for asynchronous fault inputs
`timescale 1ns/1ps
module dcf_sync #(
	parameter int WIDTH = 1
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_reg;

	// first stage feeds only the second stage
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			meta_reg <= '0;
			sync_out <= '0;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule

/* verilog/dcf_regs.sv */
// configuration and fault status register bank of the motor driver
// Overview of operation
// RULE1: configuration word two sits at AEh and resets to 01200000h.
// RULE2: bit 30 switches driver delay compensation, reset off.
// RULE3: bits 29-26 pick target delay: 0 automatic, else 0.4 to 3.2 us.
// RULE4: bit 25 picks buck switch slew, 0 fast, 1 slow, reset 0.
// RULE5: bit 24 turns buck sequencing off when set, resets to 1.
// RULE6: bits 22-21 pick buck voltage 3.3/5.0/4.0/5.7 V, reset code 1.
// RULE7: bit 20 turns the buck regulator off when set, reset 0.
// RULE8: host leaves unlisted fault map offsets alone.
// RULE9: read-only gate-driver fault word at E0h, zero after reset.
// RULE10: read-only controller fault word at E2h, zero after reset.
// RULE11: fault word bit 31 is the OR of individual driver faults.
// RULE12: bit 27 reads 0 after a supply power-on reset, else 1.
// RULE13: reserved configuration bits stay at reset value and do nothing.
`timescale 1ns/1ps
module dcf_regs
	import dcf_pkg::*;
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr_en,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_rd_en,
	output logic [31:0] reg_rdata,
	output logic reg_rd_valid,
	input wire logic [31:0] gd_fault_in,
	input wire logic supply_por_in,
	input wire logic [31:0] ctrl_fault_in,
	output logic cfg_parity,
	output logic delay_comp_en,
	output logic [3:0] target_delay_code,
	output logic target_delay_auto,
	output logic [11:0] target_delay_ns,
	output logic regulator_switch_slew,
	output logic regulator_sequencing_off,
	output logic regulator_current_low,
	output logic [1:0] regulator_voltage_sel,
	output logic regulator_off
);

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	logic [31:0] gate_driver_settings_two_reg;
	logic [31:0] gate_driver_fault_flags_reg;
	logic [31:0] controller_fault_flags_reg;
	logic [31:0] gd_fault_sync;
	logic supply_por_sync;
	logic [31:0] ctrl_fault_sync;
	logic [31:0] gd_fault_next;
	logic [31:0] settings_next;
	logic [11:0] delay_ns_next;
	logic cfg_wr_hit;

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	dcf_sync #(
		.WIDTH(32)
	) u_sync_gd (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.async_in(gd_fault_in),
		.sync_out(gd_fault_sync)
	);

	dcf_sync #(
		.WIDTH(1)
	) u_sync_por (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.async_in(supply_por_in),
		.sync_out(supply_por_sync)
	);

	dcf_sync #(
		.WIDTH(32)
	) u_sync_ctrl (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.async_in(ctrl_fault_in),
		.sync_out(ctrl_fault_sync)
	);

	// ----------------------------------------------------------------
	// configuration word
	// ----------------------------------------------------------------
	// writable fields take the write data, reserved bits keep reset value
	always_comb begin
		settings_next = (reg_wdata & DCF_CFG_WR_MASK) |
			(DCF_RST_GD_SETTINGS_TWO & ~DCF_CFG_WR_MASK); // RULE13
	end

	// write strobe aimed at the configuration word
	always_comb begin
		cfg_wr_hit = reg_wr_en && (reg_addr == DCF_OFS_GD_SETTINGS_TWO); // RULE1
	end

	// stored copy of the word, read back through the read port
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			gate_driver_settings_two_reg <= DCF_RST_GD_SETTINGS_TWO; // RULE1
		end else if (cfg_wr_hit) begin
			gate_driver_settings_two_reg <= settings_next; // RULE1
		end
	end

	// target delay in ns, zero when automatic
	always_comb begin
		if (settings_next[DCF_CFG_TDLY_MSB:DCF_CFG_TDLY_LSB] == DCF_TDLY_AUTO) begin
			delay_ns_next = 12'h000;
		end else begin
			delay_ns_next = 12'(DCF_TDLY_BASE_NS + DCF_TDLY_STEP_NS *
				(int'(settings_next[DCF_CFG_TDLY_MSB:DCF_CFG_TDLY_LSB]) - 1)); // RULE3
		end
	end

	// parity bit, stored only and never checked
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			cfg_parity <= DCF_RST_GD_SETTINGS_TWO[DCF_CFG_PARITY_BIT];
		end else if (cfg_wr_hit) begin
			cfg_parity <= settings_next[DCF_CFG_PARITY_BIT];
		end
	end

	// driver delay compensation switch
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			delay_comp_en <= DCF_RST_GD_SETTINGS_TWO[DCF_CFG_DLY_COMP_BIT]; // RULE2
		end else if (cfg_wr_hit) begin
			delay_comp_en <= settings_next[DCF_CFG_DLY_COMP_BIT]; // RULE2
		end
	end

	// target delay code, automatic flag and delay time move together
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			target_delay_code <= DCF_RST_GD_SETTINGS_TWO[DCF_CFG_TDLY_MSB:DCF_CFG_TDLY_LSB];
			target_delay_auto <= 1'b1; // RULE3
			target_delay_ns <= 12'h000;
		end else if (cfg_wr_hit) begin
			target_delay_code <= settings_next[DCF_CFG_TDLY_MSB:DCF_CFG_TDLY_LSB]; // RULE3
			target_delay_auto <=
				(settings_next[DCF_CFG_TDLY_MSB:DCF_CFG_TDLY_LSB] == DCF_TDLY_AUTO); // RULE3
			target_delay_ns <= delay_ns_next; // RULE3
		end
	end

	// buck switch slew rate, fast after reset
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			regulator_switch_slew <= DCF_RST_GD_SETTINGS_TWO[DCF_CFG_SLEW_BIT]; // RULE4
		end else if (cfg_wr_hit) begin
			regulator_switch_slew <= settings_next[DCF_CFG_SLEW_BIT]; // RULE4
		end
	end

	// buck power sequencing, off after reset
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			regulator_sequencing_off <= DCF_RST_GD_SETTINGS_TWO[DCF_CFG_SEQ_OFF_BIT]; // RULE5
		end else if (cfg_wr_hit) begin
			regulator_sequencing_off <= settings_next[DCF_CFG_SEQ_OFF_BIT]; // RULE5
		end
	end

	// buck current limit, stored as a plain field
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			regulator_current_low <= DCF_RST_GD_SETTINGS_TWO[DCF_CFG_CUR_LIM_BIT];
		end else if (cfg_wr_hit) begin
			regulator_current_low <= settings_next[DCF_CFG_CUR_LIM_BIT];
		end
	end

	// buck output voltage code
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			regulator_voltage_sel <=
				DCF_RST_GD_SETTINGS_TWO[DCF_CFG_VSEL_MSB:DCF_CFG_VSEL_LSB]; // RULE6
		end else if (cfg_wr_hit) begin
			regulator_voltage_sel <= settings_next[DCF_CFG_VSEL_MSB:DCF_CFG_VSEL_LSB]; // RULE6
		end
	end

	// buck regulator disable
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			regulator_off <= DCF_RST_GD_SETTINGS_TWO[DCF_CFG_OFF_BIT]; // RULE7
		end else if (cfg_wr_hit) begin
			regulator_off <= settings_next[DCF_CFG_OFF_BIT]; // RULE7
		end
	end

	// ----------------------------------------------------------------
	// fault status words
	// ----------------------------------------------------------------
	// assemble the gate-driver word from live fault levels
	always_comb begin
		gd_fault_next = gd_fault_sync & DCF_FLT_IND_MASK;
		gd_fault_next[DCF_FLT_SUPPLY_RST_BIT] = ~supply_por_sync; // RULE12
		gd_fault_next[DCF_FLT_SUMMARY_BIT] = |(gd_fault_sync & DCF_FLT_IND_MASK); // RULE11
	end

	// status words follow the hardware, writes never touch them
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			gate_driver_fault_flags_reg <= DCF_RST_GD_FAULT_FLAGS; // RULE9
			controller_fault_flags_reg <= DCF_RST_CTRL_FAULT_FLAGS; // RULE10
		end else begin
			gate_driver_fault_flags_reg <= gd_fault_next; // RULE9
			controller_fault_flags_reg <= ctrl_fault_sync; // RULE10
		end
	end

	// ----------------------------------------------------------------
	// read port
	// ----------------------------------------------------------------
	// read data one cycle after the strobe; unmapped reads return zero
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			reg_rdata <= 32'h00000000;
			reg_rd_valid <= 1'b0;
		end else begin
			reg_rd_valid <= reg_rd_en;
			if (reg_rd_en) begin
				unique case (reg_addr)
					DCF_OFS_GD_SETTINGS_TWO: reg_rdata <= gate_driver_settings_two_reg;
					DCF_OFS_GD_FAULT_FLAGS: reg_rdata <= gate_driver_fault_flags_reg; // RULE9
					DCF_OFS_CTRL_FAULT_FLAGS: reg_rdata <= controller_fault_flags_reg; // RULE10
					default: reg_rdata <= 32'h00000000; // RULE8
				endcase
			end
		end
	end

endmodule

/* verification/dcf_regs_assertions.sv */
// assertions on the register bank ports
`timescale 1ns/1ps
module dcf_chk
	import dcf_pkg::*;
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr_en,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_rd_en,
	input wire logic [31:0] reg_rdata,
	input wire logic delay_comp_en,
	input wire logic [3:0] target_delay_code,
	input wire logic [11:0] target_delay_ns,
	input wire logic regulator_switch_slew,
	input wire logic regulator_sequencing_off,
	input wire logic [1:0] regulator_voltage_sel,
	input wire logic regulator_off
);
	// strobes aimed at the configuration word
	wire logic cfg_wr = reg_wr_en && reg_addr == DCF_OFS_GD_SETTINGS_TWO;
	wire logic cfg_rd = reg_rd_en && reg_addr == DCF_OFS_GD_SETTINGS_TWO;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);
	chk_comp_wr: assert property (cfg_wr |=> delay_comp_en == $past(reg_wdata[30]))
		else $error("delay compensation bit wrong");
	chk_delay_time: assert property (target_delay_ns == ((target_delay_code == 4'h0) ?
		12'h000 : 12'(200 * target_delay_code + 200))) else $error("delay time wrong");
	chk_slew_wr: assert property (cfg_wr |=> regulator_switch_slew == $past(reg_wdata[25]))
		else $error("slew bit wrong");
	chk_seq_wr: assert property (cfg_wr |=> regulator_sequencing_off == $past(reg_wdata[24]))
		else $error("sequencing bit wrong");
	chk_vsel_wr: assert property (cfg_wr |=> regulator_voltage_sel == $past(reg_wdata[22:21]))
		else $error("voltage code wrong");
	chk_off_wr: assert property (cfg_wr |=> regulator_off == $past(reg_wdata[20]))
		else $error("regulator off bit wrong");
	chk_rsvd_zero: assert property (cfg_rd |=> reg_rdata[19:0] == 20'h00000)
		else $error("reserved bits not zero");
	chk_fault_sum: assert property (reg_rd_en && reg_addr == DCF_OFS_GD_FAULT_FLAGS |=>
		reg_rdata[31] == |(reg_rdata & DCF_FLT_IND_MASK)) else $error("fault summary wrong");
	chk_reset_decode: assert property ($fell(sys_rst) |-> regulator_sequencing_off &&
		regulator_voltage_sel == DCF_VSEL_5V0 && !regulator_off && !delay_comp_en &&
		!regulator_switch_slew && target_delay_code == DCF_TDLY_AUTO)
		else $error("reset decode wrong");
endmodule
bind dcf_regs dcf_chk i_chk (.*);

/* verification/dcf_host.sv */
// host model driving the register port
`timescale 1ns/1ps
module dcf_host (
	input wire logic ref_clk,
	input wire logic [31:0] reg_rdata,
	input wire logic reg_rd_valid,
	output logic [7:0] reg_addr = 8'h00,
	output logic reg_wr_en = 1'b0,
	output logic [31:0] reg_wdata = 32'h00000000,
	output logic reg_rd_en = 1'b0
);
	// one write; lines scrambled once released
	task automatic wr(input logic [7:0] a, input logic [31:0] w);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= w;
		reg_wr_en <= 1'b1;
		@(posedge ref_clk);
		reg_wr_en <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~w;
		#1;
	endtask
	// one read; answer taken the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] r, output logic v);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd_en <= 1'b1;
		@(posedge ref_clk);
		reg_rd_en <= 1'b0;
		reg_addr <= ~a;
		#1;
		v = reg_rd_valid;
		r = reg_rdata;
	endtask
endmodule

/* verification/dcf_regs_tb.sv */
// self-checking bench for the register bank
`timescale 1ns/1ps
module dcf_regs_tb
	import dcf_pkg::*;
;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic supply_por_in = 1'b1;
	logic [31:0] gd_fault_in = 32'h00000000;
	logic [31:0] ctrl_fault_in = 32'h00000000;
	logic [31:0] lfsr = 32'h00002CCC;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, d, g;
	logic reg_wr_en, reg_rd_en, reg_rd_valid, vld, cfg_parity, delay_comp_en, target_delay_auto;
	logic regulator_switch_slew, regulator_sequencing_off, regulator_current_low, regulator_off;
	logic [3:0] target_delay_code;
	logic [11:0] target_delay_ns;
	logic [1:0] regulator_voltage_sel;
	int err_count = 0;
	int n_tests = 0;
	always #4 ref_clk = ~ref_clk;
	dcf_regs i_dut (.*);
	dcf_host i_host (.*);
	// pseudo-random source
	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction
	// expected fault word: summary, inverted supply flag, masked bits
	function automatic logic [31:0] exp_fault(input logic [31:0] f, input logic por);
		logic [31:0] m;
		m = f & DCF_FLT_IND_MASK;
		return m | {|m, 3'h0, ~por, 27'h0000000};
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		i_host.rd(a, d, vld);
		check({31'h00000000, vld}, 32'h00000001);
		check(d, e);
		// valid stands one cycle, data until the next read
		@(posedge ref_clk);
		#1;
		check({31'h00000000, reg_rd_valid}, 32'h00000000);
		check(reg_rdata, e);
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (16) @(posedge ref_clk);
		sys_rst <= 1'b0;
		rdchk(DCF_OFS_GD_SETTINGS_TWO, DCF_RST_GD_SETTINGS_TWO);
		rdchk(DCF_OFS_GD_FAULT_FLAGS, DCF_RST_GD_FAULT_FLAGS);
		rdchk(DCF_OFS_CTRL_FAULT_FLAGS, DCF_RST_CTRL_FAULT_FLAGS);
		// every delay code and voltage code, random other fields
		for (int i = 0; i < 16; i++) begin
			g = rnd();
			d = {g[31:30], i[3:0], g[25:23], i[1:0], g[20:0]};
			i_host.wr(DCF_OFS_GD_SETTINGS_TWO, d);
			g = d;
			check({20'h00000, target_delay_ns}, (i == 0) ? 0 : 400 + 200 * (i - 1));
			check({31'h00000000, target_delay_auto}, {31'h00000000, i == 0});
			check({20'h00000, cfg_parity, delay_comp_en, target_delay_code, regulator_switch_slew,
				regulator_sequencing_off, regulator_current_low, regulator_voltage_sel,
				regulator_off}, {20'h00000, g[31:20]});
			rdchk(DCF_OFS_GD_SETTINGS_TWO, g & DCF_CFG_WR_MASK);
		end
		// status words refuse writes; unmapped offset reads zero
		i_host.wr(DCF_OFS_GD_FAULT_FLAGS, 32'hFFFFFFFF);
		i_host.wr(DCF_OFS_CTRL_FAULT_FLAGS, 32'hFFFFFFFF);
		rdchk(DCF_OFS_GD_FAULT_FLAGS, 32'h00000000);
		rdchk(DCF_OFS_CTRL_FAULT_FLAGS, 32'h00000000);
		rdchk(8'h10, 32'h00000000);
		// live faults: none, reserved only, then random
		for (int i = 0; i < 12; i++) begin
			g = (i == 0) ? 32'h00000000 : (i == 1) ? ~DCF_FLT_IND_MASK : rnd();
			@(posedge ref_clk);
			supply_por_in <= i[0];
			gd_fault_in <= g;
			ctrl_fault_in <= ~g;
			repeat (4) @(posedge ref_clk);
			rdchk(DCF_OFS_GD_FAULT_FLAGS, exp_fault(g, i[0]));
			rdchk(DCF_OFS_CTRL_FAULT_FLAGS, ~g);
		end
		// reset in mid-run restores the configuration word
		@(posedge ref_clk);
		sys_rst <= 1'b1;
		repeat (3) @(posedge ref_clk);
		sys_rst <= 1'b0;
		rdchk(DCF_OFS_GD_SETTINGS_TWO, DCF_RST_GD_SETTINGS_TWO);
		check({20'h00000, cfg_parity, delay_comp_en, target_delay_code, regulator_switch_slew,
			regulator_sequencing_off, regulator_current_low, regulator_voltage_sel,
			regulator_off}, {20'h00000, DCF_RST_GD_SETTINGS_TWO[31:20]});
		check({19'h00000, target_delay_auto, target_delay_ns}, 32'h00001000);
		complete_run();
	end
endmodule
